// >>> rtl/tsb_pkg.sv
// Constants and types for the touch setups block with alert output
package tsb_pkg;

   // ------------------------------------------------------------
   // Register offsets (key index travels on its own port)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_THR = 8'h00;
   localparam logic [7:0] OFF_DRIFT = 8'h30;
   localparam logic [7:0] OFF_INTEG = 8'h60;
   localparam logic [7:0] OFF_NRD = 8'h90;
   localparam logic [7:0] OFF_BURST = 8'hc0;
   localparam logic [7:0] OFF_DWELL = 8'hc1;
   localparam logic [7:0] OFF_SPACING = 8'hc2;
   localparam logic [7:0] OFF_LSL = 8'hc4;
   localparam logic [7:0] OFF_ALERT = 8'hc5;
   localparam logic [7:0] OFF_CRC = 8'hc7;

   // ------------------------------------------------------------
   // Sizes and field positions
   // ------------------------------------------------------------
   localparam int NKEYS = 48;
   localparam logic [5:0] LAST_KEY = 6'h2f;
   localparam int ALERT_POL = 7;
   localparam int ALERT_KEYERR = 6;
   localparam int ALERT_TOUCH = 5;
   localparam int ALERT_SLEEP = 4;
   localparam int ALERT_EEPROM = 3;
   localparam int ALERT_MAINS_SYNC_ENABLE = 2;
   localparam int ALERT_COMMS = 1;
   localparam int ALERT_WDOG = 0;
   localparam int BURST_AKS = 6;
   localparam int BURST_SCOPE_SYNC_ENABLE = 7;
   localparam int MAINS_SYNC_ENABLE_BIT = 6;
   localparam logic [4:0] THR_OFFSET = 5'h04;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_THR = 8'h26;
   localparam logic [7:0] RST_DRIFT = 8'h4a;
   localparam logic [7:0] RST_INTEG = 8'h52;
   localparam logic [7:0] RST_NRD = 8'h14;
   localparam logic [7:0] RST_BURST = 8'h20;
   localparam logic [7:0] RST_DWELL = 8'h10;
   localparam logic [7:0] RST_SPACING = 8'h00;
   localparam logic [15:0] RST_LSL = 16'h0064;
   localparam logic [7:0] RST_ALERT = 8'h6c;
   localparam logic [15:0] RST_CRC = 16'h0000;

   // ------------------------------------------------------------
   // Commands
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_ENTER_SETUP = 8'h01;
   // Value arbitrary, the command code is not fixed here
   localparam logic [7:0] CMD_GET_LAST = 8'h0f;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int WD_PERIOD_MS = 2000;
   localparam int WD_PULSE_MS = 150;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [4:0] neg_thr;
      logic [4:0] pos_thr;
      logic [3:0] neg_drift;
      logic [3:0] pos_drift;
      logic [3:0] normal_limit;
      logic [3:0] fast_limit;
      logic [7:0] recal_delay;
      logic [1:0] burst_code;
      logic [6:0] burst_pulses;
      logic neighbour_supp;
      logic scope_sync;
   } tsb_key_view_t;

   typedef struct packed {
      logic [1:0] dwell_code;
      logic mains_sync_en;
      logic [3:0] spacing_code;
      logic [3:0] uart_rate;
   } tsb_global_view_t;

endpackage

// >>> rtl/tsb_setup_alert.sv
// Setups register bank with alert pin and host watchdog
//
// Function
// - One 16-bit lower signal limit, default 100; reference below it flags error.
// - Alert control bit 7 selects pin polarity: one high, zero low.
// - Pin active when any enabled alert condition holds, conditions ORed.
// - Bit 6 enables key errors: calibrating, calibration failed, low signal.
// - Bit 5 makes any touched key drive the alert active.
// - Bit 4 makes the pin active during sleep; clear holds its level unchanged.
// - Bit 3 makes a setup storage error drive the alert active.
// - Bit 2 makes a mains sync error drive the alert active.
// - Bit 1 latches alert on unknown command; get-last or reset clears.
// - Bit 0 watchdog: 2 s without host traffic gives 150 ms pulse.
// - Watchdog stays disarmed until the first known command arrives.
// - Alert control byte resets to 0x6c.
// - Alert level held unchanged while asleep when bit 4 is clear.
// - Block ends with a host-supplied 16-bit CRC over preceding contents.
// - Two consecutive 0x01 commands enter setups mode; loads refused otherwise.
// - Threshold byte: negative low nibble, positive high, each plus 4.
// - Drift byte: negative code low nibble, positive high, via lookup; this block passes the codes out raw.
// - Integrator byte: normal limit low nibble, 0 disables; fast high nibble.
// - Negative recalibration delay in half seconds, 0 infinite, default 20.
// - Burst byte: length code bits 5:4 default 2, bit 6 suppression, 7 sync.
// - Dwell code bits 5:4 default 187.5 ns; bit 6 mains sync enable.
// - Spacing code low nibble, 0 automatic; uart rate code high nibble.
`timescale 1ns/1ps
`default_nettype none

module tsb_setup_alert #(
   parameter int unsigned WD_PERIOD_CYC =
      tsb_pkg::WD_PERIOD_MS * (tsb_pkg::CLK_HZ / 1000),
   parameter int unsigned WD_PULSE_CYC =
      tsb_pkg::WD_PULSE_MS * (tsb_pkg::CLK_HZ / 1000)
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_known,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [5:0] reg_key,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   output logic reg_refused,
   input wire logic ref_valid,
   input wire logic [5:0] ref_key,
   input wire logic [15:0] ref_level,
   input wire logic key_calibrating,
   input wire logic key_cal_failed,
   input wire logic key_touch,
   input wire logic sleep_active,
   input wire logic eeprom_error,
   input wire logic mains_sync_error,
   input wire logic [5:0] view_key,
   output tsb_pkg::tsb_key_view_t key_view,
   output tsb_pkg::tsb_global_view_t global_view,
   output logic setup_mode,
   output logic low_signal_error,
   output logic alert_pin
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [47:0][7:0] thr;
      logic [47:0][7:0] drift;
      logic [47:0][7:0] integ;
      logic [47:0][7:0] key_neg_recal_delay_array;
      logic [47:0][7:0] burst;
      logic [7:0] dwell;
      logic [7:0] spacing;
      logic [15:0] lower_signal_limit;
      logic [7:0] alert_ctl;
      logic [15:0] crc;
      logic [47:0] low_sig;
      logic low_err;
      logic first_enter;
      logic setup;
      logic comms_err;
      logic wd_armed;
      logic wd_pulse;
      logic [25:0] wd_cnt;
      logic pin;
      logic [15:0] rdata;
      logic ack;
      logic refused;
      tsb_pkg::tsb_key_view_t kv;
      tsb_pkg::tsb_global_view_t gv;
   } tsb_state_t;

   tsb_state_t state_ff;
   tsb_state_t nxt_state;
   logic active;
   logic key_err_any;
   logic wr_ok;

   localparam logic [25:0] WD_PERIOD_LAST = 26'(WD_PERIOD_CYC - 1);
   localparam logic [25:0] WD_PULSE_LAST = 26'(WD_PULSE_CYC - 1);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_state.ack = 1'b0;
      nxt_state.refused = 1'b0;
      // Out-of-range keys never store, even on a global offset
      wr_ok = reg_wr && state_ff.setup && reg_key <= tsb_pkg::LAST_KEY;

      // Loads are only taken in setups mode
      if (reg_wr) begin
         nxt_state.ack = 1'b1;
         nxt_state.refused = !state_ff.setup;
      end
      if (wr_ok) begin
         case (reg_addr)
            tsb_pkg::OFF_THR: nxt_state.thr[reg_key] = reg_wdata[7:0];
            tsb_pkg::OFF_DRIFT: nxt_state.drift[reg_key] = reg_wdata[7:0];
            tsb_pkg::OFF_INTEG: nxt_state.integ[reg_key] = reg_wdata[7:0];
            tsb_pkg::OFF_NRD: nxt_state.key_neg_recal_delay_array[reg_key] = reg_wdata[7:0];
            tsb_pkg::OFF_BURST: nxt_state.burst[reg_key] = reg_wdata[7:0];
            tsb_pkg::OFF_DWELL: nxt_state.dwell = reg_wdata[7:0];
            tsb_pkg::OFF_SPACING: nxt_state.spacing = reg_wdata[7:0];
            tsb_pkg::OFF_LSL: nxt_state.lower_signal_limit = reg_wdata;
            tsb_pkg::OFF_ALERT: nxt_state.alert_ctl = reg_wdata[7:0];
            // Host computes the check value; stored as given
            tsb_pkg::OFF_CRC: nxt_state.crc = reg_wdata;
            default: nxt_state.refused = 1'b1;
         endcase
      end
      if (reg_wr && reg_key > tsb_pkg::LAST_KEY) begin
         nxt_state.refused = 1'b1;
      end

      // Reads answer in any mode
      if (reg_rd) begin
         nxt_state.ack = 1'b1;
         case (reg_addr)
            tsb_pkg::OFF_THR: nxt_state.rdata = {8'h00, state_ff.thr[reg_key]};
            tsb_pkg::OFF_DRIFT: nxt_state.rdata = {8'h00, state_ff.drift[reg_key]};
            tsb_pkg::OFF_INTEG: nxt_state.rdata = {8'h00, state_ff.integ[reg_key]};
            tsb_pkg::OFF_NRD: nxt_state.rdata = {8'h00, state_ff.key_neg_recal_delay_array[reg_key]};
            tsb_pkg::OFF_BURST: nxt_state.rdata = {8'h00, state_ff.burst[reg_key]};
            tsb_pkg::OFF_DWELL: nxt_state.rdata = {8'h00, state_ff.dwell};
            tsb_pkg::OFF_SPACING: nxt_state.rdata = {8'h00, state_ff.spacing};
            tsb_pkg::OFF_LSL: nxt_state.rdata = state_ff.lower_signal_limit;
            tsb_pkg::OFF_ALERT: nxt_state.rdata = {8'h00, state_ff.alert_ctl};
            tsb_pkg::OFF_CRC: nxt_state.rdata = state_ff.crc;
            default: nxt_state.rdata = 16'h0000;
         endcase
      end

      // Setups entry needs two 0x01 commands in a row
      if (cmd_valid) begin
         if (cmd_known && cmd_code == tsb_pkg::CMD_ENTER_SETUP) begin
            nxt_state.first_enter = !state_ff.first_enter;
            if (state_ff.first_enter) begin
               nxt_state.setup = 1'b1;
            end
         end else begin
            nxt_state.first_enter = 1'b0;
            nxt_state.setup = 1'b0;
         end
      end

      // Low signal check, one key per sample
      if (ref_valid && ref_key <= tsb_pkg::LAST_KEY) begin
         nxt_state.low_sig[ref_key] = ref_level < state_ff.lower_signal_limit;
      end
      nxt_state.low_err = |nxt_state.low_sig;

      // Comms error latch; a new error beats a same-cycle clear
      if (cmd_valid && cmd_known && cmd_code == tsb_pkg::CMD_GET_LAST) begin
         nxt_state.comms_err = 1'b0;
      end
      if (cmd_valid && !cmd_known && state_ff.alert_ctl[tsb_pkg::ALERT_COMMS]) begin
         nxt_state.comms_err = 1'b1;
      end

      // Host watchdog
      if (cmd_valid && cmd_known) begin
         nxt_state.wd_armed = 1'b1;
      end
      if (!state_ff.wd_armed || !state_ff.alert_ctl[tsb_pkg::ALERT_WDOG]) begin
         nxt_state.wd_cnt = 26'h0000000;
         nxt_state.wd_pulse = 1'b0;
      end else if (state_ff.wd_pulse) begin
         // Pulse runs its full length even if traffic resumes
         nxt_state.wd_cnt = state_ff.wd_cnt + 26'h0000001;
         if (state_ff.wd_cnt == WD_PULSE_LAST) begin
            nxt_state.wd_pulse = 1'b0;
            nxt_state.wd_cnt = 26'h0000000;
         end
      end else if (cmd_valid) begin
         nxt_state.wd_cnt = 26'h0000000;
      end else begin
         nxt_state.wd_cnt = state_ff.wd_cnt + 26'h0000001;
         if (state_ff.wd_cnt == WD_PERIOD_LAST) begin
            nxt_state.wd_pulse = 1'b1;
            nxt_state.wd_cnt = 26'h0000000;
         end
      end

      // Alert conditions, ORed
      key_err_any = key_calibrating | key_cal_failed | state_ff.low_err;
      active = (state_ff.alert_ctl[tsb_pkg::ALERT_KEYERR] & key_err_any)
         | (state_ff.alert_ctl[tsb_pkg::ALERT_TOUCH] & key_touch)
         | (state_ff.alert_ctl[tsb_pkg::ALERT_SLEEP] & sleep_active)
         | (state_ff.alert_ctl[tsb_pkg::ALERT_EEPROM] & eeprom_error)
         | (state_ff.alert_ctl[tsb_pkg::ALERT_MAINS_SYNC_ENABLE] & mains_sync_error)
         | (state_ff.alert_ctl[tsb_pkg::ALERT_COMMS] & state_ff.comms_err)
         | (state_ff.alert_ctl[tsb_pkg::ALERT_WDOG] & state_ff.wd_pulse);
      // Sleep freezes the pin unless sleep itself is shown
      if (!sleep_active || state_ff.alert_ctl[tsb_pkg::ALERT_SLEEP]) begin
         nxt_state.pin = state_ff.alert_ctl[tsb_pkg::ALERT_POL] ? active : !active;
      end

      // Decoded per-key and global views
      nxt_state.kv.neg_thr = {1'b0, state_ff.thr[view_key][3:0]}
         + tsb_pkg::THR_OFFSET;
      nxt_state.kv.pos_thr = {1'b0, state_ff.thr[view_key][7:4]}
         + tsb_pkg::THR_OFFSET;
      // Time lookup belongs to the acquisition side; codes go out raw
      nxt_state.kv.neg_drift = state_ff.drift[view_key][3:0];
      nxt_state.kv.pos_drift = state_ff.drift[view_key][7:4];
      nxt_state.kv.normal_limit = state_ff.integ[view_key][3:0];
      nxt_state.kv.fast_limit = state_ff.integ[view_key][7:4];
      nxt_state.kv.recal_delay = state_ff.key_neg_recal_delay_array[view_key];
      nxt_state.kv.burst_code = state_ff.burst[view_key][5:4];
      nxt_state.kv.burst_pulses = {{1'b0, state_ff.burst[view_key][5:4]}
         + 3'h1, 4'h0};
      nxt_state.kv.neighbour_supp = state_ff.burst[view_key][tsb_pkg::BURST_AKS];
      nxt_state.kv.scope_sync = state_ff.burst[view_key][tsb_pkg::BURST_SCOPE_SYNC_ENABLE];
      nxt_state.gv.dwell_code = state_ff.dwell[5:4];
      nxt_state.gv.mains_sync_en = state_ff.dwell[tsb_pkg::MAINS_SYNC_ENABLE_BIT];
      nxt_state.gv.spacing_code = state_ff.spacing[3:0];
      nxt_state.gv.uart_rate = state_ff.spacing[7:4];
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= '0;
         state_ff.thr <= {tsb_pkg::NKEYS{tsb_pkg::RST_THR}};
         state_ff.drift <= {tsb_pkg::NKEYS{tsb_pkg::RST_DRIFT}};
         state_ff.integ <= {tsb_pkg::NKEYS{tsb_pkg::RST_INTEG}};
         state_ff.key_neg_recal_delay_array <= {tsb_pkg::NKEYS{tsb_pkg::RST_NRD}};
         state_ff.burst <= {tsb_pkg::NKEYS{tsb_pkg::RST_BURST}};
         state_ff.dwell <= tsb_pkg::RST_DWELL;
         state_ff.spacing <= tsb_pkg::RST_SPACING;
         state_ff.lower_signal_limit <= tsb_pkg::RST_LSL;
         state_ff.alert_ctl <= tsb_pkg::RST_ALERT;
         state_ff.crc <= tsb_pkg::RST_CRC;
         // Default polarity is low, so idle pin is high
         state_ff.pin <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign reg_rdata = state_ff.rdata;
   assign reg_ack = state_ff.ack;
   assign reg_refused = state_ff.refused;
   assign key_view = state_ff.kv;
   assign global_view = state_ff.gv;
   assign setup_mode = state_ff.setup;
   assign low_signal_error = state_ff.low_err;
   assign alert_pin = state_ff.pin;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   chk_touch_drives_pin: assert property (
      (key_touch && state_ff.alert_ctl[5] && !sleep_active)
      |=> alert_pin == $past(state_ff.alert_ctl[7]))
      else $error("touch did not drive alert active");

   chk_keyerr_drives_pin: assert property (
      (key_cal_failed && state_ff.alert_ctl[6] && !sleep_active)
      |=> alert_pin == $past(state_ff.alert_ctl[7]))
      else $error("key error did not drive alert active");

   chk_sleep_shown: assert property (
      (sleep_active && state_ff.alert_ctl[4])
      |=> alert_pin == $past(state_ff.alert_ctl[7]))
      else $error("sleep not shown on alert");

   chk_sleep_holds_pin: assert property (
      (sleep_active && !state_ff.alert_ctl[4]) |=> $stable(alert_pin))
      else $error("alert changed during sleep");

   chk_eeprom_alert: assert property (
      (eeprom_error && state_ff.alert_ctl[3] && !sleep_active)
      |=> alert_pin == $past(state_ff.alert_ctl[7]))
      else $error("storage error not shown");

   chk_mains_alert: assert property (
      (mains_sync_error && state_ff.alert_ctl[2] && !sleep_active)
      |=> alert_pin == $past(state_ff.alert_ctl[7]))
      else $error("mains sync error not shown");

   chk_comms_latch: assert property (
      (cmd_valid && !cmd_known && state_ff.alert_ctl[1])
      |=> state_ff.comms_err ##1 (state_ff.comms_err || $past(cmd_valid)))
      else $error("comms error not latched");

   chk_wdog_disarmed: assert property (
      !state_ff.wd_armed |-> !state_ff.wd_pulse && state_ff.wd_cnt == 26'h0000000)
      else $error("watchdog active before first command");

   chk_refuse_outside: assert property (
      (reg_wr && !state_ff.setup) |=> reg_refused && reg_ack
      && $stable(state_ff.alert_ctl) && $stable(state_ff.lower_signal_limit))
      else $error("load taken outside setups mode");

   chk_low_signal: assert property (
      (ref_valid && ref_key <= tsb_pkg::LAST_KEY && ref_level < state_ff.lower_signal_limit)
      |=> low_signal_error)
      else $error("low reference not flagged");

   // Release edge still loads reset values into the view
   chk_threshold_view: assert property (
      (resetn && !reg_wr && $stable(view_key)) |=> key_view.neg_thr
      == 5'($past(state_ff.thr[view_key][3:0])) + 5'h04)
      else $error("threshold offset wrong");

   chk_idle_level: assert property (
      (!sleep_active && !key_calibrating && !key_cal_failed && !key_touch
      && !eeprom_error && !mains_sync_error && !state_ff.low_err
      && !state_ff.comms_err && !state_ff.wd_pulse)
      |=> alert_pin == !$past(state_ff.alert_ctl[7]))
      else $error("alert not idle without conditions");

   chk_comms_cleared: assert property (
      (cmd_valid && cmd_known && cmd_code == tsb_pkg::CMD_GET_LAST)
      |=> !state_ff.comms_err)
      else $error("comms error not cleared");

   chk_setup_entry: assert property (
      (cmd_valid && cmd_known && cmd_code == tsb_pkg::CMD_ENTER_SETUP
      && state_ff.first_enter) |=> setup_mode)
      else $error("setups mode not entered");

   chk_setup_exit: assert property (
      (cmd_valid && !(cmd_known && cmd_code == tsb_pkg::CMD_ENTER_SETUP))
      |=> !setup_mode)
      else $error("setups mode kept after other command");

   // Counters bound the pulse and the silent period
   chk_wdog_pulse_len: assert property (
      state_ff.wd_pulse |-> state_ff.wd_cnt <= WD_PULSE_LAST)
      else $error("watchdog pulse too long");

   chk_wdog_period: assert property (
      !state_ff.wd_pulse |-> state_ff.wd_cnt <= WD_PERIOD_LAST)
      else $error("watchdog period overran");

   chk_wdog_fires: assert property (
      (state_ff.wd_armed && state_ff.alert_ctl[0] && !state_ff.wd_pulse && !cmd_valid
      && state_ff.wd_cnt == WD_PERIOD_LAST) |=> state_ff.wd_pulse)
      else $error("watchdog pulse did not start");

endmodule

`default_nettype wire

// >>> test/tsb_host_model.sv
// Host model that issues command bytes to the setups block
`timescale 1ns/1ps
`default_nettype none

module tsb_host_model (
   input wire logic clk,
   output var logic cmd_valid,
   output var logic [7:0] cmd_code,
   output var logic cmd_known
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_known = 1'b0;
   end

   // Idle lines show inverted data so a stale code never looks fresh
   task automatic send(input logic [7:0] code, input logic known);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code <= code;
      cmd_known <= known;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_code <= ~code;
      cmd_known <= ~known;
   endtask

   task automatic enter_setup();
      send(8'h01, 1'b1);
      send(8'h01, 1'b1);
   endtask
endmodule

`default_nettype wire

// >>> test/tsb_setup_alert_test.sv
// Self-checking bench for the setups block and alert pin
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch at %0t got %h exp %h", $time, g, e); end end

module tsb_setup_alert_test;
   localparam int AB[6] = '{6, 6, 5, 4, 3, 2};
   logic clk, resetn, reg_wr, reg_rd, ref_valid, cmd_valid, cmd_known;
   logic setup_mode, low_signal_error, alert_pin, reg_ack, reg_refused;
   logic [7:0] reg_addr, cmd_code;
   logic [5:0] reg_key, ref_key, view_key, cond;
   logic [15:0] reg_wdata, reg_rdata, ref_level;
   tsb_pkg::tsb_key_view_t key_view;
   tsb_pkg::tsb_global_view_t global_view;
   int err_total = 0;
   int tests_run = 0;
   int n;

   tsb_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_known(cmd_known));

   // Short watchdog counts keep the run brief
   tsb_setup_alert #(.WD_PERIOD_CYC(40), .WD_PULSE_CYC(6)) dut (
      .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_known(cmd_known), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_key(reg_key), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_refused(reg_refused), .ref_valid(ref_valid),
      .ref_key(ref_key), .ref_level(ref_level), .key_calibrating(cond[0]),
      .key_cal_failed(cond[1]), .key_touch(cond[2]), .sleep_active(cond[3]),
      .eeprom_error(cond[4]), .mains_sync_error(cond[5]), .view_key(view_key),
      .key_view(key_view), .global_view(global_view), .setup_mode(setup_mode),
      .low_signal_error(low_signal_error), .alert_pin(alert_pin));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [5:0] k, input logic [15:0] d,
      input logic refd);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_key <= k;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      #1;
      `CHK(reg_ack, 1'b1)
      `CHK(reg_refused, refd)
   endtask

   task automatic rd(input logic [7:0] a, input logic [5:0] k, input logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      reg_key <= k;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_ack, 1'b1)
      `CHK(reg_rdata, e)
   endtask

   task automatic ref_sample(input logic [15:0] l);
      @(posedge clk);
      ref_valid <= 1'b1;
      ref_key <= 6'h03;
      ref_level <= l;
      @(posedge clk);
      ref_valid <= 1'b0;
      ref_level <= ~l;
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Whole sequence needs well under 2000 cycles
   initial begin
      #(50 * 4000);
      err_total++;
      complete_run();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      {reg_wr, reg_rd, ref_valid, reg_addr, reg_key, ref_key, view_key, cond} = '0;
      reg_wdata = 16'h0000;
      ref_level = 16'hffff;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      tick(2);
      `CHK(alert_pin, 1'b1)
      `CHK(key_view.burst_code, 2'h2)
      `CHK(key_view.burst_pulses, 7'h30)
      `CHK(key_view.recal_delay, 8'h14)
      `CHK(global_view.dwell_code, 2'h1)
      rd(tsb_pkg::OFF_ALERT, 6'h00, 16'h006c);
      rd(tsb_pkg::OFF_LSL, 6'h00, 16'h0064);
      wr(tsb_pkg::OFF_ALERT, 6'h00, 16'h0000, 1'b1);
      host.send(8'h01, 1'b1);
      host.send(8'h07, 1'b1);
      tick(2);
      `CHK(setup_mode, 1'b0)
      host.enter_setup();
      tick(1);
      `CHK(setup_mode, 1'b1)
      @(posedge clk) view_key <= 6'h2f;
      wr(tsb_pkg::OFF_THR, 6'h2f, 16'h005a, 1'b0);
      wr(tsb_pkg::OFF_DRIFT, 6'h2f, 16'h003c, 1'b0);
      wr(tsb_pkg::OFF_INTEG, 6'h2f, 16'h0071, 1'b0);
      wr(tsb_pkg::OFF_BURST, 6'h2f, 16'h00f0, 1'b0);
      wr(tsb_pkg::OFF_DWELL, 6'h00, 16'h0060, 1'b0);
      wr(tsb_pkg::OFF_SPACING, 6'h00, 16'h0043, 1'b0);
      wr(tsb_pkg::OFF_CRC, 6'h00, 16'hbeef, 1'b0);
      wr(tsb_pkg::OFF_THR, 6'h30, 16'h0011, 1'b1);
      wr(8'hc3, 6'h00, 16'h0011, 1'b1);
      rd(8'hc3, 6'h00, 16'h0000);
      rd(tsb_pkg::OFF_CRC, 6'h00, 16'hbeef);
      rd(tsb_pkg::OFF_THR, 6'h2f, 16'h005a);
      `CHK(key_view.neg_thr, 5'h0e)
      `CHK(key_view.pos_thr, 5'h09)
      `CHK(key_view.neg_drift, 4'hc)
      `CHK(key_view.pos_drift, 4'h3)
      `CHK(key_view.normal_limit, 4'h1)
      `CHK(key_view.fast_limit, 4'h7)
      `CHK({key_view.scope_sync, key_view.neighbour_supp, key_view.burst_code}, 4'hf)
      `CHK(key_view.burst_pulses, 7'h40)
      `CHK({global_view.mains_sync_en, global_view.dwell_code}, 3'h6)
      `CHK({global_view.uart_rate, global_view.spacing_code}, 8'h43)
      for (int i = 0; i < 6; i++) begin
         wr(tsb_pkg::OFF_ALERT, 6'h00, 16'h0080 | (16'h0001 << AB[i]), 1'b0);
         @(posedge clk) cond <= 6'h01 << i;
         tick(2);
         `CHK(alert_pin, 1'b1)
         @(posedge clk) cond <= 6'h00;
         tick(2);
         `CHK(alert_pin, 1'b0)
      end
      wr(tsb_pkg::OFF_ALERT, 6'h00, 16'h0080, 1'b0);
      @(posedge clk) cond <= 6'h37;
      tick(2);
      `CHK(alert_pin, 1'b0)
      wr(tsb_pkg::OFF_ALERT, 6'h00, 16'h0020, 1'b0);
      tick(2);
      `CHK(alert_pin, 1'b0)
      @(posedge clk) cond <= 6'h00;
      tick(2);
      `CHK(alert_pin, 1'b1)
      wr(tsb_pkg::OFF_ALERT, 6'h00, 16'h00a0, 1'b0);
      @(posedge clk) cond <= 6'h04;
      tick(2);
      `CHK(alert_pin, 1'b1)
      @(posedge clk) cond <= 6'h08;
      tick(3);
      `CHK(alert_pin, 1'b1)
      @(posedge clk) cond <= 6'h00;
      tick(2);
      `CHK(alert_pin, 1'b0)
      wr(tsb_pkg::OFF_ALERT, 6'h00, 16'h00c0, 1'b0);
      ref_sample(16'h0063);
      tick(2);
      `CHK(low_signal_error, 1'b1)
      `CHK(alert_pin, 1'b1)
      ref_sample(16'h0064);
      tick(2);
      `CHK(low_signal_error, 1'b0)
      wr(tsb_pkg::OFF_ALERT, 6'h00, 16'h0082, 1'b0);
      host.send(8'h33, 1'b0);
      tick(3);
      `CHK(alert_pin, 1'b1)
      `CHK(setup_mode, 1'b0)
      host.send(tsb_pkg::CMD_GET_LAST, 1'b1);
      tick(3);
      `CHK(alert_pin, 1'b0)
      host.enter_setup();
      wr(tsb_pkg::OFF_ALERT, 6'h00, 16'h0081, 1'b0);
      host.send(8'h01, 1'b1);
      tick(30);
      `CHK(alert_pin, 1'b0)
      n = 0;
      while (alert_pin !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      `CHK(n < 20, 1'b1)
      n = 0;
      while (alert_pin === 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      `CHK(n, 6)
      @(posedge clk) resetn <= 1'b0;
      tick(1);
      `CHK(alert_pin, 1'b1)
      `CHK(setup_mode, 1'b0)
      @(posedge clk) resetn <= 1'b1;
      tick(2);
      `CHK(alert_pin, 1'b1)
      rd(tsb_pkg::OFF_ALERT, 6'h00, 16'h006c);
      complete_run();
   end
endmodule

`default_nettype wire
